// ---- src/ssr_defs.vh ----
// Purpose: Constants for the status summary and service request block
// Assumes: Eight-bit status summary, bit n weighs two to the power n
// Notes:   Included by bare name from the status byte design file only
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH
`define SSR_WIDTH        8
`define SSR_BIT_SUB_DONE 0
`define SSR_BIT_LIMIT    1
`define SSR_BIT_REQ_CMD  2
`define SSR_BIT_PWR_ON   3
`define SSR_BIT_READY    4
`define SSR_BIT_ERROR    5
`define SSR_BIT_SVC_REQ  6
`define SSR_BIT_DATA     7
`define SSR_STATUS_RESET 8'h08
`define SSR_MASK_RESET   8'h00
`define SSR_KEEP_MASK    8'h70
`endif

// ---- src/ssr_cond_latch.v ----
// Purpose: Sticky status bits with conditional clear
// Assumes: Set events and live conditions are synchronous to clk
// Notes:   A set in the clear cycle wins over the clear
`timescale 1ns/1ps
module ssr_cond_latch #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = 8'h08,
  parameter [WIDTH-1:0] KEEP_MASK   = 8'h70
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] set_event,
  input  wire [WIDTH-1:0] cond_live,
  input  wire             clear,
  output reg  [WIDTH-1:0] bits
);
  reg [WIDTH-1:0] next_bits;

  // Keep bits whose condition still exists, then apply new sets
  always @*
  begin
    next_bits = bits;
    if (clear)
      next_bits = bits & KEEP_MASK & cond_live;
    next_bits = next_bits | set_event;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bits <= RESET_VALUE;
    else
      bits <= next_bits;
  end
endmodule // ssr_cond_latch

// ---- src/ssr_status_byte.v ----
// Purpose: Status summary byte and service request generator
// Assumes: Commands arrive as one-cycle strobes synchronous to clk
// Notes:   Query answer is registered one cycle after the strobe
//          Service bit 6 is live, not sticky: it follows the enabled bits
//          Ready sets on the rising edge of its condition only
//          Mask bit 6 has no effect, so the service bit never counts toward the request
`timescale 1ns/1ps
`include "ssr_defs.vh"
module ssr_status_byte #(
  parameter WIDTH = `SSR_WIDTH
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             ev_sub_done,
  input  wire             ev_limit,
  input  wire             ev_req_cmd,
  input  wire             ev_data,
  input  wire             ready_cond,
  input  wire             error_cond,
  input  wire             ev_error,
  input  wire             status_summary_query,
  input  wire             clear_status_command,
  input  wire             request_mask_command,
  input  wire [WIDTH-1:0] mask_data,
  output reg  [WIDTH-1:0] query_data,
  output reg              query_valid,
  output reg  [WIDTH-1:0] status_view,
  output reg  [WIDTH-1:0] request_mask,
  output reg              srq
);
  // Field positions of the ready bit hidden from the answer and of the service bit kept outside the sticky latch
  localparam integer POS_READY = `SSR_BIT_READY;
  localparam integer POS_SVC   = `SSR_BIT_SVC_REQ;

  // Sticky bits from the latch; bit 6 is never set there
  wire [WIDTH-1:0] bits;
  reg  [WIDTH-1:0] status_byte;
  reg  [WIDTH-1:0] next_query_data;

  // Event and condition vectors, and the service helpers
  reg  [WIDTH-1:0] set_event;
  reg  [WIDTH-1:0] cond_live;
  reg              svc_pending;
  reg              svc_flag;
  reg              ready_seen;

  // One-hot mask for a position of the status byte
  function [WIDTH-1:0] ssr_bit_mask;
    input integer pos;
    begin
      ssr_bit_mask      = {WIDTH{1'b0}};
      ssr_bit_mask[pos] = 1'b1;
    end
  endfunction

  // Answer seen by the host: ready is hidden while the query is served
  function [WIDTH-1:0] ssr_answer;
    input [WIDTH-1:0] status;
    begin
      ssr_answer = status & ~ssr_bit_mask(POS_READY);
    end
  endfunction

  // Any enabled bit other than the service bit; bit 6 would hold itself up
  function ssr_any_enabled;
    input [WIDTH-1:0] status;
    input [WIDTH-1:0] mask;
    begin
      ssr_any_enabled = |(status & mask & ~ssr_bit_mask(POS_SVC));
    end
  endfunction

  // Ready is raised on its rising condition so a clear can drop it later
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ready_seen <= 1'b0;
    end
    else
    begin
      ready_seen <= ready_cond;
    end
  end

  // Service bit is registered from the pending request, so it drops one cycle after its cause
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      svc_flag <= 1'b0;
    end
    else
    begin
      svc_flag <= svc_pending;
    end
  end

  // Full status byte: latched bits with the live service bit in place
  always @*
  begin
    status_byte = bits & ~ssr_bit_mask(POS_SVC);
    if (svc_flag)
    begin
      status_byte = status_byte | ssr_bit_mask(POS_SVC);
    end
  end

  // Request test on the full byte against the mask
  always @*
  begin
    svc_pending = ssr_any_enabled(status_byte, request_mask);
  end

  // Event vector into the sticky latch
  always @*
  begin
    set_event                    = {WIDTH{1'b0}};
    set_event[`SSR_BIT_SUB_DONE] = ev_sub_done;
    set_event[`SSR_BIT_LIMIT]    = ev_limit;
    set_event[`SSR_BIT_REQ_CMD]  = ev_req_cmd;
    set_event[`SSR_BIT_PWR_ON]   = 1'b0; // Set by reset only
    set_event[`SSR_BIT_READY]    = ready_cond & ~ready_seen;
    set_event[`SSR_BIT_ERROR]    = ev_error;
    set_event[`SSR_BIT_SVC_REQ]  = 1'b0; // Kept outside the latch
    set_event[`SSR_BIT_DATA]     = ev_data;
  end

  // Conditions that hold a bit over a clear
  always @*
  begin
    cond_live                 = {WIDTH{1'b0}};
    cond_live[`SSR_BIT_READY] = ready_cond;
    cond_live[`SSR_BIT_ERROR] = error_cond;
  end

  // Sticky storage; a set in the clear cycle wins
  ssr_cond_latch #(
    .WIDTH       (WIDTH),
    .RESET_VALUE (`SSR_STATUS_RESET),
    .KEEP_MASK   (`SSR_KEEP_MASK)
  ) u_latch (
    .clk       (clk),
    .reset_n   (reset_n),
    .set_event (set_event),
    .cond_live (cond_live),
    .clear     (clear_status_command),
    .bits      (bits)
  );

  // Mask register, written only by its own command
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      request_mask <= `SSR_MASK_RESET;
    end
    else if (request_mask_command)
    begin
      request_mask <= mask_data;
    end
  end

  // Answer held until the next query, so a slow host can still read it
  always @*
  begin
    next_query_data = query_data;
    if (status_summary_query)
    begin
      next_query_data = ssr_answer(status_byte);
    end
  end

  // Query strobe answered one cycle later with a one-cycle valid
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      query_data  <= {WIDTH{1'b0}};
      query_valid <= 1'b0;
    end
    else
    begin
      query_data  <= next_query_data;
      query_valid <= status_summary_query;
    end
  end

  // View of the byte for the host side, one cycle behind the latch
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_view <= `SSR_STATUS_RESET;
    end
    else
    begin
      status_view <= status_byte;
    end
  end

  // Bus service line, registered alongside the service bit
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      srq <= 1'b0;
    end
    else
    begin
      srq <= svc_pending;
    end
  end
endmodule // ssr_status_byte

// ---- test/ssr_status_byte_chk.sv ----
// Purpose: Port checker for the status byte block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into the design below the module
`timescale 1ns/1ps
module ssr_chk #(
  parameter WIDTH = 8
) (
  input wire             clk,
  input wire             reset_n,
  input wire             ev_error,
  input wire             ready_cond,
  input wire             status_summary_query,
  input wire             clear_status_command,
  input wire             request_mask_command,
  input wire             srq,
  input wire             query_valid,
  input wire [WIDTH-1:0] mask_data,
  input wire [WIDTH-1:0] query_data,
  input wire [WIDTH-1:0] status_view,
  input wire [WIDTH-1:0] request_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_query_answer: assert property (status_summary_query |=> query_valid)
    else $error("no answer");
  a_ready_hidden: assert property (query_valid |-> !query_data[4])
    else $error("ready shown");
  a_answer_hold: assert property (!status_summary_query |=> $stable(query_data))
    else $error("answer moved");
  a_mask_write: assert property (request_mask_command |=> request_mask == $past(mask_data))
    else $error("mask lost");
  a_svc_bit: assert property (status_view[6] == $past(srq))
    else $error("svc bit");
  a_srq_cause: assert property (srq == |($past(request_mask) & status_view & 8'hBF))
    else $error("srq cause");
  a_clear_drops: assert property (clear_status_command && !ready_cond ##1 !ready_cond
    |=> status_view[4:3] == 2'h0) else $error("clear kept");
  a_error_set: assert property (ev_error |=> ##1 status_view[5])
    else $error("error bit");
endmodule // ssr_chk
bind ssr_status_byte ssr_chk #(
  .WIDTH (WIDTH)
) chk (
  .clk                  (clk),
  .reset_n              (reset_n),
  .ev_error             (ev_error),
  .ready_cond           (ready_cond),
  .status_summary_query (status_summary_query),
  .clear_status_command (clear_status_command),
  .request_mask_command (request_mask_command),
  .srq                  (srq),
  .query_valid          (query_valid),
  .mask_data            (mask_data),
  .query_data           (query_data),
  .status_view          (status_view),
  .request_mask         (request_mask)
);

// ---- test/ssr_host.sv ----
// Purpose: Host controller model
// Assumes: One command a cycle
// Notes:   1 query, 2 clear, 3 mask
`timescale 1ns/1ps
module ssr_host (
  input  wire logic [1:0] op,
  output logic            query,
  output logic            clear,
  output logic            mask
);
  // Decode so two commands can never overlap
  assign query = (op == 2'h1);
  assign clear = (op == 2'h2);
  assign mask  = (op == 2'h3);
endmodule // ssr_host

// ---- test/tb_ssr_status_byte.sv ----
// Purpose: Status byte bench
// Assumes: Latencies as handed over
// Notes:   Fixed waits only
`timescale 1ns/1ps
module tb_ssr_status_byte;
  logic clk = 0, reset_n = 0, rdy = 0, err = 0, q, c, m, qv, srq, qv_seen = 0;
  logic [1:0] op = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [7:0] md = 8'h00, qd, sv, rm;
  int bad_count = 0, comparisons = 0;
  initial forever #5 clk = ~clk;
  ssr_host host (.op(op), .query(q), .clear(c), .mask(m));
  ssr_status_byte dut (.clk(clk), .reset_n(reset_n), .ev_sub_done(ev[0]), .ev_limit(ev[1]),
    .ev_req_cmd(ev[2]), .ev_data(ev[3]), .ready_cond(rdy), .error_cond(err), .ev_error(ev[4]),
    .status_summary_query(q), .clear_status_command(c), .request_mask_command(m),
    .mask_data(md), .query_data(qd), .query_valid(qv), .status_view(sv),
    .request_mask(rm), .srq(srq));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One command and event burst; valid caught while it stands, then settle
  task run(logic [1:0] o, logic [4:0] e, logic r);
    @(posedge clk) {op, ev, rdy} <= {o, e, r};
    @(posedge clk) {op, ev} <= 7'h00;
    #1 qv_seen = qv;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1;
    run(2'h0, 5'h00, 0);
    chk("power on", 8'h08, sv);
    chk("srq idle", 8'h00, {7'h00, srq});
    run(2'h1, 5'h00, 1);
    chk("idle byte", 8'h18, sv);
    chk("idle answer", 8'h08, qd);
    chk("answer valid", 8'h01, {7'h00, qv_seen});
    chk("valid pulse", 8'h00, {7'h00, qv});
    run(2'h0, 5'h1F, 1);
    chk("all events", 8'hBF, sv);
    chk("no answer", 8'h00, {7'h00, qv_seen});
    run(2'h1, 5'h00, 1);
    chk("sum", 8'hAF, qd);
    $display("test events done");
    @(posedge clk) md <= 8'h80;
    run(2'h3, 5'h00, 1);
    chk("mask", 8'h80, rm);
    chk("masked", 8'hFF, sv);
    chk("srq on", 8'h01, {7'h00, srq});
    run(2'h1, 5'h00, 1);
    chk("svc answer", 8'hEF, qd);
    $display("test mask done");
    @(posedge clk) err <= 1'b1;
    run(2'h2, 5'h00, 1);
    chk("kept live", 8'h30, sv);
    chk("srq off", 8'h00, {7'h00, srq});
    @(posedge clk) err <= 1'b0;
    run(2'h2, 5'h00, 0);
    chk("cleared", 8'h00, sv);
    $display("test clear done");
    report_and_stop();
  end
endmodule // tb_ssr_status_byte
